// file: rtl/bus_demux_decode.sv
// splits the multiplexed controller bus and decodes memory enables
// How it works
// [R01] low port carries low address then data within one external cycle
// [R02] low address byte follows the port while latch strobe high, kept for rest of cycle
// [R03] upper address byte taken straight from the high port, never latched
// [R04] rom enable for 0000-3fff, ram enable for 4000-bfff
// [R05] four expansion selects, 4 KB each, c000 through ffff in order
// [R06] read and write strobes qualify transfers and go to the connector
// [R07] of the address only the low four latched bits reach the connector, alongside the data byte
// [R08] spare eight-bit port passed through unchanged to the connector
// [R09] all enables active low, at most one asserted per address
`timescale 1ns/10ps
`default_nettype none
`include "bus_demux_defs.svh"

module bus_demux_decode (
    input  wire logic                    mclk_i,
    input  wire logic                    resetn_i,
    input  wire logic [7:0]              low_port_i,
    input  wire logic [7:0]              high_port_i,
    input  wire logic                    addr_latch_strobe_i,
    input  wire logic                    rd_n_i,
    input  wire logic                    wr_n_i,
    input  wire logic [7:0]              spare_port_i,
    output logic      [15:0]             address_o,
    output logic      [7:0]              data_o,
    output bus_demux_pkg::enables_t      enables_o,
    output bus_demux_pkg::connector_t    connector_o
);
    // ------------------------------------------------------------
    // pin capture
    // ------------------------------------------------------------
    logic [7:0] low_s;
    logic [7:0] high_s;
    logic [7:0] spare_s;
    logic       ale_s;
    logic       rd_n_s;
    logic       wr_n_s;

    pin_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_low (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .pin_i    (low_port_i),
        .level_o  (low_s)
    );
    pin_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_high (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .pin_i    (high_port_i),
        .level_o  (high_s)
    );
    pin_sync #(.WIDTH(8), .RESET_VAL(8'hff)) u_spare (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .pin_i    (spare_port_i),
        .level_o  (spare_s)
    );
    // strobes idle high; ale idle low
    pin_sync #(.WIDTH(3), .RESET_VAL(3'b110)) u_ctl (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .pin_i    ({rd_n_i, wr_n_i, addr_latch_strobe_i}),
        .level_o  ({rd_n_s, wr_n_s, ale_s})
    );

    // ------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------
    logic [7:0] low_addr_q;

    // transparent while strobe high, holds afterwards
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_addr_q <= 8'h00;
        end else if (ale_s) begin
            low_addr_q <= low_s; // [R01] [R02]
        end
    end

    logic [15:0] addr;
    assign addr = {high_s, ale_s ? low_s : low_addr_q}; // [R02] [R03]

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic bus_demux_pkg::enables_t decode(input logic [15:0] a);
        logic [3:0] pg;
        pg = a[15:12];
        decode = '{rom_en_n: 1'b1, ram_en_n: 1'b1,
                   expansion_select_n: 4'hf};
        if (pg <= `ROM_LAST_PAGE) begin
            decode.rom_en_n = 1'b0; // [R04]
        end else if (pg <= `RAM_LAST_PAGE) begin
            decode.ram_en_n = 1'b0; // [R04]
        end else begin
            // one-hot page index, exclusive by construction
            decode.expansion_select_n[2'(pg - `EXP_FIRST_PAGE)] = 1'b0; // [R05] [R09]
        end
    endfunction

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic [7:0] data_q;

    // data byte follows the port every cycle while the strobe is low, i.e. data phase
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_q <= 8'h00;
        end else if (!ale_s) begin
            data_q <= low_s; // [R01]
        end
    end
    assign data_o = data_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            address_o <= 16'h0000;
            enables_o <= '{rom_en_n: 1'b1, ram_en_n: 1'b1,
                           expansion_select_n: 4'hf}; // [R09]
        end else begin
            address_o <= addr; // [R03]
            enables_o <= decode(addr); // [R04] [R05] [R09]
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            connector_o <= '{rd_n: 1'b1, wr_n: 1'b1,
                             low_nibble_location_lines: 4'h0,
                             shared_byte_lines: 8'h00,
                             spare_port_lines: 8'hff};
        end else begin
            connector_o.rd_n <= rd_n_s; // [R06]
            connector_o.wr_n <= wr_n_s; // [R06]
            connector_o.low_nibble_location_lines <=
                addr[`LOW_NIBBLE_W-1:0]; // [R07]
            connector_o.shared_byte_lines <= ale_s ? data_q : low_s; // [R07]
            connector_o.spare_port_lines  <= spare_s; // [R08]
        end
    end
endmodule // bus_demux_decode

`default_nettype wire

// file: rtl/bus_demux_defs.svh
// constants for the multiplexed bus splitter and address decoder
`ifndef BUS_DEMUX_DEFS_SVH
`define BUS_DEMUX_DEFS_SVH

`define ROM_LAST_PAGE    4'h3
`define RAM_FIRST_PAGE   4'h4
`define RAM_LAST_PAGE    4'hb
`define EXP_FIRST_PAGE   4'hc
`define EXP_SELECTS      4
`define LOW_NIBBLE_W     4
`define SYNC_STAGES      3

`endif

// file: rtl/bus_demux_pkg.sv
// types shared by the bus splitter files
package bus_demux_pkg;
    typedef struct packed {
        logic       rom_en_n;
        logic       ram_en_n;
        logic [3:0] expansion_select_n;
    } enables_t;

    typedef struct packed {
        logic       rd_n;
        logic       wr_n;
        logic [3:0] low_nibble_location_lines;
        logic [7:0] shared_byte_lines;
        logic [7:0] spare_port_lines;
    } connector_t;
endpackage

// file: rtl/pin_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
`include "bus_demux_defs.svh"

module pin_sync #(
    parameter int            WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_q    <= RESET_VAL;
            s2_q    <= RESET_VAL;
            s3_q    <= RESET_VAL;
            level_o <= RESET_VAL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // per-bit agreement filters a single-cycle glitch
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // pin_sync

`default_nettype wire

// file: verification/bus_demux_decode_tb.sv
// self-checking bench for the bus splitter and decoder
`timescale 1ns/10ps
`default_nettype none
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t %h %h", $time, g, e); end end
module bus_demux_decode_tb;
    logic mclk_i = 0, resetn_i = 0, strb = 0, rd_n = 1, wr_n = 1;
    logic [7:0] lo = 0, hi = 0, sp = 0, d_o;
    logic [15:0] a_o;
    logic [11:0] last;
    bus_demux_pkg::enables_t en;
    bus_demux_pkg::connector_t con;
    int num_errors = 0, n_checks = 0, seed = 32'h59ed, i;
    logic [15:0] bnd [12] = '{16'h0000, 16'h3fff, 16'h4000, 16'hbfff,
        16'hc000, 16'hcfff, 16'hd000, 16'hdfff, 16'he000, 16'hefff,
        16'hf000, 16'hffff};
    initial forever #2.5 mclk_i = ~mclk_i;
    bus_demux_decode DUT (.mclk_i, .resetn_i, .low_port_i(lo),
        .high_port_i(hi), .addr_latch_strobe_i(strb), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .spare_port_i(sp), .address_o(a_o), .data_o(d_o),
        .enables_o(en), .connector_o(con));
    periph_model PM (.mclk_i, .en_i(en), .con_i(con), .last_o(last));
    function automatic logic [5:0] exp_en(int a);
        int p;
        p = a >> 12;
        return {p > 3, p < 4 || p > 11, p > 11 ? ~(4'h1 << (p - 12)) : 4'hf};
    endfunction
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                       input logic w);
        hi = a[15:8]; lo = a[7:0]; strb = 1; sp = 8'($random(seed));
        repeat (8) @(negedge mclk_i); strb = 0;
        repeat (8) @(negedge mclk_i); lo = d; rd_n = w; wr_n = !w;
        repeat (8) @(negedge mclk_i);
        `CK({con.rd_n, con.wr_n}, {w, !w})
        rd_n = 1; wr_n = 1;
        repeat (8) @(negedge mclk_i);
        `CK(a_o, a)
        `CK(en, exp_en(a))
        `CK(con.low_nibble_location_lines, a[3:0])
        `CK(d_o, d)
        `CK(con.shared_byte_lines, d)
        `CK(con.spare_port_lines, sp)
        if (a[15:12] == 4'hc && w) `CK(last, {a[3:0], d})
    endtask
    initial begin
        repeat (10) @(negedge mclk_i);
        resetn_i = 1;
        for (i = 0; i < 40; i++)
            cyc(i < 12 ? bnd[i] : 16'($random(seed)), 8'($random(seed)), !i[0]);
        stop_test();
    end
endmodule // bus_demux_decode_tb
`default_nettype wire

// file: verification/bus_demux_props.sv
// checker for the splitter and decoder outputs
`timescale 1ns/10ps
`default_nettype none
module bus_demux_props (
    input wire logic mclk_i, resetn_i, addr_latch_strobe_i, rd_n_i, wr_n_i,
    input wire logic [7:0] low_port_i, high_port_i, spare_port_i, data_o,
    input wire logic [15:0] address_o,
    input wire bus_demux_pkg::enables_t enables_o,
    input wire bus_demux_pkg::connector_t connector_o
);
    // outputs settle only after the sync pipe fills
    logic [3:0] n_q;
    wire ok = n_q[3];
    always_ff @(posedge mclk_i or negedge resetn_i)
        if (!resetn_i) n_q <= 4'h0;
        else if (!ok) n_q <= n_q + 4'h1;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    wire [15:0] a = address_o;
    property p_rom; ok |-> enables_o.rom_en_n == (a > 16'h3fff); endproperty
    a_rom: assert property (p_rom) else $error("rom enable");
    property p_ram; ok |-> enables_o.ram_en_n == (a[15] == a[14]); endproperty
    a_ram: assert property (p_ram) else $error("ram enable");
    property p_exp; ok |-> enables_o.expansion_select_n ==
        (a[15:14] == 2'h3 ? ~(4'h1 << a[13:12]) : 4'hf); endproperty
    a_exp: assert property (p_exp) else $error("window select");
    property p_one; ok |-> $onehot(~enables_o); endproperty
    a_one: assert property (p_one) else $error("enable count");
    property p_nib; ok |->
        connector_o.low_nibble_location_lines == a[3:0]; endproperty
    a_nib: assert property (p_nib) else $error("nibble");
    property p_hi; ok && $stable(high_port_i) [*6] |->
        a[15:8] == high_port_i; endproperty
    a_hi: assert property (p_hi) else $error("high byte");
    property p_sp; ok && $stable(spare_port_i) [*6] |->
        connector_o.spare_port_lines == spare_port_i; endproperty
    a_sp: assert property (p_sp) else $error("spare port");
    property p_st; ok && $stable({rd_n_i, wr_n_i}) [*6] |->
        {connector_o.rd_n, connector_o.wr_n} == {rd_n_i, wr_n_i}; endproperty
    a_st: assert property (p_st) else $error("strobes");
endmodule // bus_demux_props
bind bus_demux_decode bus_demux_props u_props (.mclk_i, .resetn_i,
    .addr_latch_strobe_i, .rd_n_i, .wr_n_i, .low_port_i, .high_port_i,
    .spare_port_i, .data_o, .address_o, .enables_o, .connector_o);
`default_nettype wire

// file: verification/periph_model.sv
// attached board model: keeps the last byte written to window zero
`timescale 1ns/10ps
`default_nettype none
module periph_model (
    input  wire logic                       mclk_i,
    input  wire bus_demux_pkg::enables_t    en_i,
    input  wire bus_demux_pkg::connector_t  con_i,
    output logic [11:0]                     last_o
);
    logic w_q;
    always_ff @(posedge mclk_i) begin
        w_q <= con_i.wr_n;
        // take at trailing strobe edge, data long settled by then
        if (!w_q && con_i.wr_n && !en_i.expansion_select_n[0])
            last_o <= {con_i.low_nibble_location_lines, con_i.shared_byte_lines};
    end
endmodule // periph_model
`default_nettype wire
